// ==== src/vpif_cfg.svh ====
// Register offsets, field positions and reset values of the video port interrupt flags
`ifndef VPIF_CFG_SVH
`define VPIF_CFG_SVH
`define VPIF_OFF_ENABLE 12'h000
`define VPIF_OFF_STATUS 12'h004
`define VPIF_OFF_CHB_CTRL 12'h008
`define VPIF_OFF_EVENT 12'h00C
`define VPIF_ADDR_W 12
`define VPIF_BIT_GLOBAL 0
`define VPIF_BIT_LONG_B 23
`define VPIF_BIT_SHORT_B 22
`define VPIF_BIT_OVR_B 17
`define VPIF_ENABLE_MASK 32'h00FF7CFF
`define VPIF_STATUS_MASK 32'h00FF7CFE
`define VPIF_ENABLE_RST 32'h00000000
`define VPIF_STATUS_RST 32'h00000000
`define VPIF_CTRL_RST 32'h00000000
`define VPIF_CTRL_MASK 32'h00000FFF
`define VPIF_LINE_W 12
`endif

// ==== src/vpif_pkg.sv ====
// Types shared by the video port interrupt flags block
package vpif_pkg;
   typedef enum logic [1:0] {VPIF_MODE_VIDEO, VPIF_MODE_YC, VPIF_MODE_RAW, VPIF_MODE_TSI}
      vpif_mode_t;
endpackage

// ==== src/vpif_irq.sv ====
// Interrupt enable and status flags of a video port, APB slave
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "vpif_cfg.svh"
module vpif_irq
(
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`VPIF_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Event strobes, same clock, one bit per status position
   input wire logic [31:0] event_set,
   // Channel B line counter view
   input wire logic line_count_reset,
   input wire logic [`VPIF_LINE_W-1:0] line_counter,
   input wire logic fifo_overwrite_b,
   // Interrupt to the processor core
   output logic irq
);
   // Register file
   logic [31:0] irq_enable_mask_reg;
   logic [31:0] irq_enable_mask_next;
   logic [31:0] irq_status_flags_reg;
   logic [31:0] irq_status_flags_next;
   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   // Bus answer, registered so outputs come from flops
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic irq_reg;
   logic irq_next;
   // Channel B field detector
   logic [`VPIF_LINE_W-1:0] vertical_stop_value;
   logic vertical_reset_select;
   logic long_detect_en;
   logic short_detect_en;
   logic field_done_reg;
   logic field_done_next;
   vpif_pkg::vpif_mode_t mode;
   logic capture_video;
   logic set_long;
   logic set_short;
   // Bus decode
   logic wr;
   logic rd;
   logic access;
   logic [31:0] hw_set;

   // Channel B control: mode/reset select/detect bits in ctrl[4:0], stop line is ctrl[11:5] shifted left by 5
   assign mode = vpif_pkg::vpif_mode_t'(ctrl_reg[1:0]);
   assign vertical_reset_select = ctrl_reg[2];
   assign long_detect_en = ctrl_reg[3];
   assign short_detect_en = ctrl_reg[4];
   assign vertical_stop_value = {5'h00, ctrl_reg[11:5]} << 5;
   assign capture_video = (mode == vpif_pkg::VPIF_MODE_VIDEO) || (mode == vpif_pkg::VPIF_MODE_YC);

   assign access = psel && penable && pce;
   assign wr = access && pwrite;
   assign rd = access && !pwrite;

   always_comb
   begin
      set_long = 1'b0;
      set_short = 1'b0;
      field_done_next = field_done_reg;
      if (capture_video)
      begin
         if (line_count_reset)
         begin
            // Short field: reset came before the stop line
            set_short = short_detect_en && (line_counter < vertical_stop_value);
            field_done_next = 1'b0;
         end
         else if (line_counter == vertical_stop_value + `VPIF_LINE_W'(1) && !field_done_reg)
         begin
            set_long = long_detect_en;
            field_done_next = 1'b1;
         end
         // Vertical reset select keeps reporting the long field
         if (vertical_reset_select && long_detect_en && line_count_reset)
            set_long = 1'b1;
      end
      hw_set = event_set;
      hw_set[`VPIF_BIT_LONG_B] = set_long;
      hw_set[`VPIF_BIT_SHORT_B] = set_short;
      hw_set[`VPIF_BIT_OVR_B] = event_set[`VPIF_BIT_OVR_B] | fifo_overwrite_b;
      hw_set = hw_set & `VPIF_STATUS_MASK;
   end

   always_comb
   begin
      irq_enable_mask_next = irq_enable_mask_reg;
      ctrl_next = ctrl_reg;
      irq_status_flags_next = irq_status_flags_reg;
      pready_next = psel && !penable;
      pslverr_next = 1'b0;
      prdata_next = 32'h00000000;
      if (wr && paddr == `VPIF_OFF_ENABLE)
         irq_enable_mask_next = pwdata & `VPIF_ENABLE_MASK;
      if (wr && paddr == `VPIF_OFF_CHB_CTRL)
         ctrl_next = pwdata & `VPIF_CTRL_MASK;
      if (wr && paddr == `VPIF_OFF_STATUS)
         irq_status_flags_next = irq_status_flags_reg & ~pwdata;
      // Set applied after clear so no event is lost
      irq_status_flags_next = (irq_status_flags_next | hw_set) & `VPIF_STATUS_MASK;
      if (psel && !penable)
      begin
         unique case (paddr)
            `VPIF_OFF_ENABLE: prdata_next = irq_enable_mask_reg;
            `VPIF_OFF_STATUS: prdata_next = irq_status_flags_reg;
            `VPIF_OFF_CHB_CTRL: prdata_next = ctrl_reg;
            `VPIF_OFF_EVENT: prdata_next = 32'h00000000;
            default: pslverr_next = 1'b1;
         endcase
      end
      irq_next = irq_enable_mask_next[`VPIF_BIT_GLOBAL]
         && |(irq_status_flags_next & irq_enable_mask_next & `VPIF_STATUS_MASK);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_enable_mask_reg <= `VPIF_ENABLE_RST;
         irq_status_flags_reg <= `VPIF_STATUS_RST;
         ctrl_reg <= `VPIF_CTRL_RST;
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         irq_reg <= 1'b0;
         field_done_reg <= 1'b0;
      end
      else if (pce)
      begin
         irq_enable_mask_reg <= irq_enable_mask_next;
         irq_status_flags_reg <= irq_status_flags_next;
         ctrl_reg <= ctrl_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         irq_reg <= irq_next;
         field_done_reg <= field_done_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq = irq_reg;

   a_irq_needs_global: assert property (@(posedge pclk) disable iff (!presetn)
      irq |-> irq_enable_mask_reg[`VPIF_BIT_GLOBAL])
      else $error("irq high with global enable low");
   a_irq_level_track: assert property (@(posedge pclk) disable iff (!presetn)
      pce |=> irq == (irq_enable_mask_reg[0]
      && |(irq_status_flags_reg & irq_enable_mask_reg)))
      else $error("irq does not follow masked flags");
   a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      ((irq_status_flags_reg & ~`VPIF_STATUS_MASK) == 32'h0)
      && ((irq_enable_mask_reg & ~`VPIF_ENABLE_MASK) == 32'h0))
      else $error("reserved bit set");
   a_set_wins_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (pce && hw_set[20]) |=> irq_status_flags_reg[20])
      else $error("event lost");
   a_w1c_clears: assert property (@(posedge pclk) disable iff (!presetn)
      (pce && wr && paddr == `VPIF_OFF_STATUS && pwdata[13] && !hw_set[13])
      |=> !irq_status_flags_reg[13])
      else $error("write one did not clear");
   a_w0_keeps: assert property (@(posedge pclk) disable iff (!presetn)
      (pce && irq_status_flags_reg[3] && !(wr && paddr == `VPIF_OFF_STATUS && pwdata[3]))
      |=> irq_status_flags_reg[3])
      else $error("flag lost without clear");
   a_no_long_raw: assert property (@(posedge pclk) disable iff (!presetn)
      !capture_video |-> !set_long)
      else $error("long field outside capture");
   a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
      (pce && wr && paddr == `VPIF_OFF_ENABLE) |=> irq_enable_mask_reg[10] == $past(pwdata[10]))
      else $error("enable bit not stored");
   a_overrun_sets: assert property (@(posedge pclk) disable iff (!presetn)
      (pce && fifo_overwrite_b) |=> irq_status_flags_reg[`VPIF_BIT_OVR_B])
      else $error("overrun flag not set");
   a_irq_from_flag: assert property (@(posedge pclk) disable iff (!presetn)
      irq |-> |(irq_status_flags_reg & irq_enable_mask_reg & `VPIF_STATUS_MASK))
      else $error("irq high with no enabled flag");
   a_status_bit0_zero: assert property (@(posedge pclk) disable iff (!presetn)
      !irq_status_flags_reg[0])
      else $error("status bit 0 set");
   a_enable_rsvd_read: assert property (@(posedge pclk) disable iff (!presetn)
      (pce && psel && !penable && paddr == `VPIF_OFF_ENABLE)
      |=> (prdata[31:24] == 8'h00) && !prdata[15] && (prdata[9:8] == 2'h0))
      else $error("enable reserved bits read nonzero");
   a_status_rsvd_read: assert property (@(posedge pclk) disable iff (!presetn)
      (pce && psel && !penable && paddr == `VPIF_OFF_STATUS)
      |=> (prdata[31:24] == 8'h00) && !prdata[15] && (prdata[9:8] == 2'h0) && !prdata[0])
      else $error("status reserved bits read nonzero");
   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      (pce && psel && !penable && !(paddr inside {`VPIF_OFF_ENABLE, `VPIF_OFF_STATUS,
      `VPIF_OFF_CHB_CTRL, `VPIF_OFF_EVENT}))
      |=> pslverr && (prdata == 32'h00000000))
      else $error("unmapped address not refused");
   a_enable_holds: assert property (@(posedge pclk) disable iff (!presetn)
      (pce && !(wr && paddr == `VPIF_OFF_ENABLE)) |=> $stable(irq_enable_mask_reg))
      else $error("enable changed without write");
   a_long_sets: assert property (@(posedge pclk) disable iff (!presetn)
      (pce && set_long) |=> irq_status_flags_reg[`VPIF_BIT_LONG_B])
      else $error("long field flag not set");
   a_short_sets: assert property (@(posedge pclk) disable iff (!presetn)
      (pce && set_short) |=> irq_status_flags_reg[`VPIF_BIT_SHORT_B])
      else $error("short field flag not set");
   a_no_short_raw: assert property (@(posedge pclk) disable iff (!presetn)
      !capture_video |-> !set_short)
      else $error("short field outside capture");
   a_long_needs_en: assert property (@(posedge pclk) disable iff (!presetn)
      set_long |-> long_detect_en)
      else $error("long field without detect enable");
   a_vrs_long: assert property (@(posedge pclk) disable iff (!presetn)
      (capture_video && vertical_reset_select && long_detect_en && line_count_reset)
      |-> set_long)
      else $error("vertical reset select did not force long field");
   a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == `VPIF_OFF_CHB_CTRL)
      |=> ctrl_reg == ($past(pwdata) & `VPIF_CTRL_MASK))
      else $error("control not stored");
   a_flags_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      (pce && !(wr && paddr == `VPIF_OFF_STATUS))
      |=> ((irq_status_flags_reg & $past(irq_status_flags_reg)) == $past(irq_status_flags_reg)))
      else $error("flag dropped without clear");
   a_flags_by_event: assert property (@(posedge pclk) disable iff (!presetn)
      (pce && hw_set == 32'h00000000)
      |=> ((irq_status_flags_reg & ~$past(irq_status_flags_reg)) == 32'h00000000))
      else $error("flag set without event");
   a_frozen: assert property (@(posedge pclk) disable iff (!presetn)
      !pce |=> $stable(irq_enable_mask_reg) && $stable(irq_status_flags_reg) && $stable(irq))
      else $error("state moved while clock enable low");
   a_irq_drops: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == `VPIF_OFF_STATUS && pwdata == 32'hFFFFFFFF && hw_set == 32'h00000000)
      |=> !irq)
      else $error("irq stayed after full clear");
   a_time_clock_sets: assert property (@(posedge pclk) disable iff (!presetn)
      (pce && hw_set[10]) |=> irq_status_flags_reg[10])
      else $error("time clock flag not set");
   c_irq_rises: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
   c_vrs_long: cover property (@(posedge pclk) disable iff (!presetn)
      set_long && vertical_reset_select);
   c_long_field: cover property (@(posedge pclk) disable iff (!presetn) set_long);
   c_short_field: cover property (@(posedge pclk) disable iff (!presetn) set_short);
   c_set_and_clear: cover property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == `VPIF_OFF_STATUS && |(pwdata & hw_set));
endmodule

// ==== testbench/vpif_cpu_model.sv ====
// Processor core interrupt input: counts rising edges of the request
`timescale 1ns/10ps
module vpif_cpu_model
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Request from the port
   input wire logic irq,
   output logic [7:0] irq_seen
);
   logic irq_d;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_d <= 1'b0;
         irq_seen <= 8'h00;
      end
      else
      begin
         irq_d <= irq;
         irq_seen <= irq_seen + {7'h00, irq & ~irq_d};
      end
   end
endmodule

// ==== testbench/vpif_irq_tb_top.sv ====
// Self-checking bench for the video port interrupt flags
`timescale 1ns/10ps
module vpif_irq_tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic line_count_reset = 0, fifo_overwrite_b = 0, pready, pslverr, irq;
   logic [11:0] paddr = 0, line_counter = 0;
   logic [31:0] pwdata = 0, event_set = 0, prdata, rd;
   logic [7:0] irq_seen;
   int error_cnt = 0, n_compared = 0;
   initial forever #2.5 pclk = ~pclk;
   vpif_irq i_vpif_irq(.pclk, .presetn, .pce(1'b1), .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .event_set, .line_count_reset, .line_counter,
      .fifo_overwrite_b, .irq);
   vpif_cpu_model i_vpif_cpu_model(.pclk, .presetn, .irq, .irq_seen);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_of_test;
      $display("mismatches %0d of %0d compared", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // One transfer; idles a cycle after so psel is never reassigned in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (i == 50)
      begin
         error_cnt++;
         end_of_test();
      end
      rd = pslverr ? 32'hEEEEEEEE : prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic ev(input logic [31:0] e, input logic lr, input logic fo);
      event_set <= e;
      line_count_reset <= lr;
      fifo_overwrite_b <= fo;
      @(posedge pclk);
      event_set <= 32'h00000000;
      line_count_reset <= 1'b0;
      fifo_overwrite_b <= 1'b0;
      @(posedge pclk);
      apb(1'b0, 12'h004, 32'h00000000);
   endtask
   task t_reset;
      apb(1'b0, 12'h000, 32'h00000000);
      check(rd, 32'h00000000);
      apb(1'b0, 12'h004, 32'h00000000);
      check(rd, 32'h00000000);
      apb(1'b0, 12'h010, 32'h00000000);
      check(rd, 32'hEEEEEEEE);
      check({24'h0, irq_seen}, 32'h00000000);
   endtask
   task t_mask;
      apb(1'b1, 12'h000, 32'hFFFFFFFF);
      apb(1'b0, 12'h000, 32'h00000000);
      check(rd, 32'h00FF7CFF);
      apb(1'b1, 12'h000, 32'h00FF7CFE);
      ev(32'hFFFFFFFF, 1'b0, 1'b0);
      check(rd, 32'h003F7CFE);
      check({31'h0, irq}, 32'h00000000);
      apb(1'b1, 12'h000, 32'h00000001);
      check({31'h0, irq}, 32'h00000000);
      apb(1'b1, 12'h000, 32'h00000401);
      check({31'h0, irq}, 32'h00000001);
      apb(1'b1, 12'h004, 32'h00000000);
      apb(1'b0, 12'h004, 32'h00000000);
      check(rd, 32'h003F7CFE);
      apb(1'b1, 12'h004, 32'hFFFFFFFF);
      apb(1'b0, 12'h004, 32'h00000000);
      check(rd, 32'h00000000);
      check({31'h0, irq}, 32'h00000000);
      check({24'h0, irq_seen}, 32'h00000001);
   endtask
   task t_field;
      apb(1'b1, 12'h008, 32'h00000028);
      line_counter <= 12'h021;
      ev(32'h00000000, 1'b0, 1'b0);
      check(rd, 32'h00800000);
      apb(1'b1, 12'h004, 32'hFFFFFFFF);
      // Raw mode with forced long field: would set the flag in video capture
      apb(1'b1, 12'h008, 32'h0000002E);
      ev(32'h00000000, 1'b1, 1'b0);
      check(rd, 32'h00000000);
      apb(1'b1, 12'h008, 32'h0000002C);
      line_counter <= 12'h005;
      ev(32'h00000000, 1'b1, 1'b0);
      check(rd, 32'h00800000);
      apb(1'b1, 12'h004, 32'hFFFFFFFF);
      apb(1'b1, 12'h008, 32'h00000030);
      ev(32'h00000000, 1'b1, 1'b0);
      check(rd, 32'h00400000);
      apb(1'b1, 12'h004, 32'hFFFFFFFF);
      ev(32'h00000000, 1'b0, 1'b1);
      check(rd, 32'h00020000);
      apb(1'b1, 12'h004, 32'hFFFFFFFF);
   endtask
   // Event strobe lands on the very edge that takes the clearing write
   task t_race;
      fork
         apb(1'b1, 12'h004, 32'hFFFFFFFF);
         begin
            @(posedge pclk);
            event_set <= 32'h00100000;
            @(posedge pclk);
            event_set <= 32'h00000000;
         end
      join
      apb(1'b0, 12'h004, 32'h00000000);
      check(rd, 32'h00100000);
   endtask
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_mask();
      t_field();
      t_race();
      // Second reset with state left set
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      end_of_test();
   end
endmodule
